//--- hsc_pkg.sv
package hsc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Management addressing.
  localparam logic [4:0]  DEV_ADDR       = 5'h1E;
  localparam logic [15:0] REG_POWER      = 16'h0001;
  localparam logic [15:0] REG_PLL        = 16'h0002;
  localparam logic [15:0] REG_TXRX       = 16'h0003;

  // Values after reset.
  localparam logic [15:0] RST_PLL        = 16'h831D;
  localparam logic [15:0] RST_TXRX       = 16'hA848;
  localparam logic        RST_POWER_OFF  = 1'b0;
  localparam logic [15:0] RST_ADDR       = 16'h0000;

  // Field positions in the power register.
  localparam int          POWER_OFF_BIT  = 15;

  // Field positions in the PLL control register.
  localparam int          RSVD_HI_LSB    = 10;
  localparam int          PLL_BW_LSB     = 8;
  localparam int          RSVD_B7_BIT    = 7;
  localparam int          VCO_RANGE_BIT  = 6;
  localparam int          RSVD_B5_BIT    = 5;
  localparam int          PLL_EN_BIT     = 4;
  localparam int          PLL_MULT_LSB   = 0;

  // Field positions in the transmit and receive analog register.
  localparam int          SWING_LSB      = 12;
  localparam int          TX_EN_BIT      = 11;
  localparam int          EQ_HOLD_BIT    = 10;
  localparam int          TX_RATE_LSB    = 8;
  localparam int          AGC_LSB        = 6;
  localparam int          AZ_LSB         = 4;

  // Frame layout counts, in management clock periods.
  localparam logic [5:0]  PREAMBLE_LEN   = 6'h20;
  localparam logic [4:0]  HDR_BITS       = 5'h0E;
  localparam logic [4:0]  DATA_BITS      = 5'h10;

  // Frame start and operation codes.
  localparam logic [1:0]  ST_CL45        = 2'h0;
  localparam logic [1:0]  OP_ADDRESS     = 2'h0;
  localparam logic [1:0]  OP_WRITE       = 2'h1;
  localparam logic [1:0]  OP_READ_INC    = 2'h2;
  localparam logic [1:0]  OP_READ        = 2'h3;

  // Frame receiver states.
  typedef enum logic [3:0] {
    FR_PRE  = 4'h1,
    FR_HDR  = 4'h2,
    FR_TA   = 4'h4,
    FR_DATA = 4'h8
  } hsc_frame_e;

  // Static controls presented to the analog serdes macro.
  typedef struct packed {
    logic [1:0] pll_loop_bw_sel;
    logic       vco_low_range;
    logic       pll_enable;
    logic [3:0] pll_multiplier_code;
    logic [6:0] pll_mult_x4;
    logic       pll_mult_reserved;
    logic [3:0] tx_amplitude_code;
    logic       tx_enable;
    logic       equalizer_freeze;
    logic [1:0] tx_rate_code;
    logic [1:0] gain_loop_mode;
    logic [1:0] auto_zero_mode;
    logic       datapath_off;
  } hsc_ana_s;

  // Multiplier code to factor in quarter steps; reserved codes give zero.
  function automatic logic [6:0] mult_x4(input logic [3:0] code);
    logic [6:0] f;
    f = 7'h00;
    unique case (code)
      4'h2:    f = 7'h10;
      4'h3:    f = 7'h14;
      4'h4:    f = 7'h18;
      4'h5:    f = 7'h20;
      4'h6:    f = 7'h21;
      4'h7:    f = 7'h28;
      4'h8:    f = 7'h30;
      4'h9:    f = 7'h32;
      4'hA:    f = 7'h3C;
      4'hB:    f = 7'h40;
      4'hC:    f = 7'h42;
      4'hD:    f = 7'h50;
      4'hE:    f = 7'h64;
      default: f = 7'h00;
    endcase
    return f;
  endfunction

endpackage

//--- hsc_sync.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Two flip-flop synchroniser for a group of pin inputs.
module hsc_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("hsc_sync needs at least one bit.");
    end
  endgenerate

  logic [WIDTH-1:0] meta_r;

  // Each bit passes two flops; only the second stage leaves this module.
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          meta_r[gi]   <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end
        else
        begin
          meta_r[gi]   <= pin_in[gi];
          pin_sync[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

endmodule // hsc_sync

//--- hsc_regs.sv
`timescale 1ns/1ns
// Summary of operation
// RULE1 - PLL register at 0x0002, resets 0x831D.
// RULE2 - Analog register at 0x0003, resets 0xA848.
// RULE3 - Reserved bits read-write, documented reset values.
// RULE4 - Loop bandwidth code drives PLL bandwidth.
// RULE5 - VCO range bit selects low range.
// RULE6 - Software sets low range below 2.5 GHz.
// RULE7 - PLL enable gated by power-down pin, bit.
// RULE8 - Multiplier code resets 1101, drives PLL.
// RULE9 - Multiplier codes map to listed factors.
// RULE10 - Swing code resets 1010, drives amplitude.
// RULE11 - Transmit enable gated by power-down controls.
// RULE12 - Equalizer freeze holds adaptation state.
// RULE13 - Transmit rate code full to eighth.
// RULE14 - Gain loop mode drives attenuator behaviour.
// RULE15 - Auto-zero mode drives calibration behaviour.
// RULE16 - Global power-off bit at 0x0001 bit 15.
// RULE17 - Fields held in flops, applied continuously.
module hsc_regs (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             mdc,
  input  wire logic             mdio_in,
  output logic                  mdio_out,
  output logic                  mdio_oe,
  input  wire logic [4:0]       port_addr,
  input  wire logic             channel_global_power_off_n,
  output hsc_pkg::hsc_ana_s     ana
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.
  logic [7:0] pins_s;
  logic       mdc_s;
  logic       mdio_s;
  logic       pd_n_s;
  logic [4:0] prt_s;

  hsc_sync #(
    .WIDTH    (8)
  ) u_sync (
    .clock    (clock),
    .rst      (rst),
    .pin_in   ({port_addr, channel_global_power_off_n, mdio_in, mdc}),
    .pin_sync (pins_s)
  );

  assign mdc_s  = pins_s[0];
  assign mdio_s = pins_s[1];
  assign pd_n_s = pins_s[2];
  assign prt_s  = pins_s[7:3];

  ////////////////////////////////////////////////////////////////////////////////
  // State.
  hsc_pkg::hsc_frame_e state_r, state_nxt;
  logic        mdc_d_r,  mdc_d_nxt;
  logic [5:0]  pre_r,    pre_nxt;
  logic [4:0]  cnt_r,    cnt_nxt;
  logic [13:0] hdr_r,    hdr_nxt;
  logic [15:0] sh_r,     sh_nxt;
  logic [15:0] addr_r,   addr_nxt;
  logic [15:0] pll_r,    pll_nxt;
  logic [15:0] txrx_r,   txrx_nxt;
  logic        poff_r,   poff_nxt;
  logic        out_r,    out_nxt;
  logic        oe_r,     oe_nxt;
  hsc_pkg::hsc_ana_s ana_r, ana_nxt;

  logic        mdc_rise;
  logic        sel;
  logic        is_read;
  logic [1:0]  op;
  logic [15:0] rdata;
  logic [15:0] wdata;

  // Frame decode from the captured header: start, operation, port, device.
  assign mdc_rise = mdc_s & ~mdc_d_r;
  assign op       = hdr_r[11:10];
  assign sel      = (hdr_r[13:12] == hsc_pkg::ST_CL45) && (hdr_r[9:5] == prt_s)
                    && (hdr_r[4:0] == hsc_pkg::DEV_ADDR);
  assign is_read  = sel && (op == hsc_pkg::OP_READ || op == hsc_pkg::OP_READ_INC);
  assign wdata    = {sh_r[14:0], mdio_s};

  // Read data for the addressed register; unmapped addresses read zero.
  always_comb
  begin
    rdata = 16'h0000;
    if (addr_r == hsc_pkg::REG_POWER)
      rdata[hsc_pkg::POWER_OFF_BIT] = poff_r; // RULE16
    else if (addr_r == hsc_pkg::REG_PLL)
      rdata = pll_r; // RULE1
    else if (addr_r == hsc_pkg::REG_TXRX)
      rdata = txrx_r; // RULE2
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Management frame receiver and register writes, advanced on each mdc rise.
  always_comb
  begin
    state_nxt = state_r;
    mdc_d_nxt = mdc_s;
    pre_nxt   = pre_r;
    cnt_nxt   = cnt_r;
    hdr_nxt   = hdr_r;
    sh_nxt    = sh_r;
    addr_nxt  = addr_r;
    pll_nxt   = pll_r;
    txrx_nxt  = txrx_r;
    poff_nxt  = poff_r;
    out_nxt   = out_r;
    oe_nxt    = oe_r;
    if (mdc_rise)
    begin
      unique case (state_r)
        hsc_pkg::FR_PRE:
        begin
          if (mdio_s)
          begin
            if (pre_r != hsc_pkg::PREAMBLE_LEN)
              pre_nxt = pre_r + 6'h01;
          end
          else if (pre_r == hsc_pkg::PREAMBLE_LEN)
          begin
            state_nxt = hsc_pkg::FR_HDR;
            hdr_nxt   = 14'h0000;
            cnt_nxt   = 5'h01;
            pre_nxt   = 6'h00;
          end
          else
            pre_nxt = 6'h00;
        end
        hsc_pkg::FR_HDR:
        begin
          hdr_nxt = {hdr_r[12:0], mdio_s};
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == hsc_pkg::HDR_BITS - 5'h01)
          begin
            state_nxt = hsc_pkg::FR_TA;
            cnt_nxt   = 5'h00;
          end
        end
        hsc_pkg::FR_TA:
        begin
          if (cnt_r == 5'h00)
          begin
            cnt_nxt = 5'h01;
            if (is_read)
            begin
              oe_nxt  = 1'b1; // Second turnaround bit is driven low.
              out_nxt = 1'b0;
            end
          end
          else
          begin
            state_nxt = hsc_pkg::FR_DATA;
            cnt_nxt   = 5'h00;
            out_nxt   = rdata[15];
            sh_nxt    = {rdata[14:0], 1'b0};
          end
        end
        hsc_pkg::FR_DATA:
        begin
          cnt_nxt = cnt_r + 5'h01;
          sh_nxt  = wdata;
          out_nxt = sh_r[15];
          if (cnt_r == hsc_pkg::DATA_BITS - 5'h01)
          begin
            state_nxt = hsc_pkg::FR_PRE;
            cnt_nxt   = 5'h00;
            oe_nxt    = 1'b0;
            out_nxt   = 1'b0;
            if (sel && op == hsc_pkg::OP_ADDRESS)
              addr_nxt = wdata;
            if (sel && op == hsc_pkg::OP_READ_INC)
              addr_nxt = addr_r + 16'h0001;
            if (sel && op == hsc_pkg::OP_WRITE)
            begin
              if (addr_r == hsc_pkg::REG_PLL)
                pll_nxt = wdata; // RULE3
              if (addr_r == hsc_pkg::REG_TXRX)
                txrx_nxt = wdata;
              if (addr_r == hsc_pkg::REG_POWER)
                poff_nxt = wdata[hsc_pkg::POWER_OFF_BIT]; // RULE16
            end
          end
        end
      endcase
    end
  end

  // Registers the frame receiver and the configuration words.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_r <= hsc_pkg::FR_PRE;
      mdc_d_r <= 1'b0;
      pre_r   <= 6'h00;
      cnt_r   <= 5'h00;
      hdr_r   <= 14'h0000;
      sh_r    <= 16'h0000;
      addr_r  <= hsc_pkg::RST_ADDR;
      pll_r   <= hsc_pkg::RST_PLL; // RULE1
      txrx_r  <= hsc_pkg::RST_TXRX; // RULE2
      poff_r  <= hsc_pkg::RST_POWER_OFF;
      out_r   <= 1'b0;
      oe_r    <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      mdc_d_r <= mdc_d_nxt;
      pre_r   <= pre_nxt;
      cnt_r   <= cnt_nxt;
      hdr_r   <= hdr_nxt;
      sh_r    <= sh_nxt;
      addr_r  <= addr_nxt;
      pll_r   <= pll_nxt;
      txrx_r  <= txrx_nxt;
      poff_r  <= poff_nxt;
      out_r   <= out_nxt;
      oe_r    <= oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Analog macro controls, recomputed every cycle from the stored fields.
  always_comb
  begin
    ana_nxt                     = '0;
    ana_nxt.pll_loop_bw_sel     = pll_r[hsc_pkg::PLL_BW_LSB +: 2]; // RULE4
    ana_nxt.vco_low_range       = pll_r[hsc_pkg::VCO_RANGE_BIT]; // RULE5
    ana_nxt.pll_enable          = pll_r[hsc_pkg::PLL_EN_BIT] & pd_n_s & ~poff_r; // RULE7
    ana_nxt.pll_multiplier_code = pll_r[hsc_pkg::PLL_MULT_LSB +: 4]; // RULE8
    ana_nxt.pll_mult_x4         = hsc_pkg::mult_x4(pll_r[hsc_pkg::PLL_MULT_LSB +: 4]); // RULE9
    ana_nxt.pll_mult_reserved   = (ana_nxt.pll_mult_x4 == 7'h00); // RULE9
    ana_nxt.tx_amplitude_code   = txrx_r[hsc_pkg::SWING_LSB +: 4]; // RULE10
    ana_nxt.tx_enable           = txrx_r[hsc_pkg::TX_EN_BIT] & pd_n_s & ~poff_r; // RULE11
    ana_nxt.equalizer_freeze    = txrx_r[hsc_pkg::EQ_HOLD_BIT]; // RULE12
    ana_nxt.tx_rate_code        = txrx_r[hsc_pkg::TX_RATE_LSB +: 2]; // RULE13
    ana_nxt.gain_loop_mode      = txrx_r[hsc_pkg::AGC_LSB +: 2]; // RULE14
    ana_nxt.auto_zero_mode      = txrx_r[hsc_pkg::AZ_LSB +: 2]; // RULE15
    ana_nxt.datapath_off        = poff_r | ~pd_n_s; // RULE16
  end

  // Holds the controls in flops so a finished write simply takes effect.
  always_ff @(posedge clock)
  begin
    if (rst)
      ana_r <= '0;
    else
      ana_r <= ana_nxt; // RULE17
  end

  assign ana      = ana_r;
  assign mdio_out = out_r;
  assign mdio_oe  = oe_r;

endmodule // hsc_regs

//--- hsc_mdio_host.sv
`timescale 1ns/1ns
////////////////////////
// Management host model; mdc stands low between frames.
module hsc_mdio_host (
  input  wire logic clock,
  input  wire logic pin,
  output logic      mdc,
  output logic      drv,
  output logic      val
);
  // Idle with mdc low and the pin released.
  initial
  begin
    mdc = 1'b0;
    drv = 1'b0;
    val = 1'b0;
  end
  // One bit: data set while mdc is low, pin sampled just before mdc rises.
  task automatic bit_x(input logic d, input logic v, output logic s);
    mdc <= 1'b0;
    drv <= d;
    val <= v;
    repeat (4) @(posedge clock);
    @(negedge clock);
    s = pin;
    @(posedge clock);
    mdc <= 1'b1;
    repeat (5) @(posedge clock);
  endtask
  // A read frame releases the pin from the turnaround on.
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] dv,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] h;
    logic        s;
    h = {hsc_pkg::ST_CL45, op, pa, dv};
    for (int i = 0; i < 32; i++) bit_x(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_x(1'b1, h[i], s);
    bit_x(!op[1], 1'b1, s);
    bit_x(!op[1], 1'b0, s);
    for (int i = 15; i >= 0; i--)
    begin
      bit_x(!op[1], wd[i], s);
      rd[i] = s;
    end
    mdc <= 1'b0;
    drv <= 1'b0;
    repeat (10) @(posedge clock);
  endtask
endmodule // hsc_mdio_host

//--- hsc_regs_chk.sv
`timescale 1ns/1ns
////////////////////////
// Checks reset values, enable gating and timing against mdc.
module hsc_regs_chk (
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              mdc,
  input wire logic              mdio_in,
  input wire logic              mdio_out,
  input wire logic              mdio_oe,
  input wire logic [4:0]        port_addr,
  input wire logic              channel_global_power_off_n,
  input wire hsc_pkg::hsc_ana_s ana
);
  logic        mdc_r;
  logic [3:0]  age_r;
  logic [3:0]  age_nxt;
  logic [17:0] cfg;
  // Static fields, which move only after a management write.
  assign cfg = {ana.pll_loop_bw_sel, ana.vco_low_range, ana.pll_multiplier_code,
                ana.tx_amplitude_code, ana.equalizer_freeze, ana.tx_rate_code,
                ana.gain_loop_mode, ana.auto_zero_mode};
  // Cycles since the last mdc rise or reset, saturating at 15.
  always_comb
  begin
    age_nxt = (age_r == 4'hF) ? age_r : age_r + 4'h1;
    if (rst || (mdc && !mdc_r))
      age_nxt = 4'h0;
  end
  // Registers the mdc history.
  always_ff @(posedge clock)
  begin
    mdc_r <= mdc;
    age_r <= age_nxt;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_released;
    !$past(rst) && !$past(rst, 2) && $past(rst, 3);
  endsequence
  sequence s_pd_low;
    !channel_global_power_off_n [*5];
  endsequence
  cfg_timing_a: assert property (!$stable(cfg) |-> age_r <= 4'h8)
    else $error("config moved without a write");
  pll_gate_a: assert property (ana.pll_enable |-> !ana.datapath_off)
    else $error("pll on while powered down");
  tx_gate_a: assert property (ana.tx_enable |-> !ana.datapath_off)
    else $error("tx on while powered down");
  pin_off_a: assert property (s_pd_low |-> ana.datapath_off && !ana.pll_enable
    && !ana.tx_enable)
    else $error("pin power-down ignored");
  // The controls read all zero for one cycle after release, so skip that cycle.
  mult_rsvd_a: assert property (!$past(rst) |-> ana.pll_mult_reserved ==
    (ana.pll_multiplier_code inside {4'h0, 4'h1, 4'hF}))
    else $error("reserved flag wrong");
  mult_zero_a: assert property (!$past(rst) |-> (ana.pll_mult_x4 == 7'h00) ==
    (ana.pll_multiplier_code inside {4'h0, 4'h1, 4'hF}))
    else $error("factor wrong for code");
  pll_rst_a: assert property (s_released |->
    {ana.pll_loop_bw_sel, ana.vco_low_range, ana.pll_multiplier_code} == 7'h6D)
    else $error("pll reset value wrong");
  txrx_rst_a: assert property (s_released |->
    {ana.tx_amplitude_code, ana.equalizer_freeze, ana.tx_rate_code, ana.gain_loop_mode,
     ana.auto_zero_mode} == 11'h504)
    else $error("txrx reset value wrong");
  drive_start_a: assert property ($rose(mdio_oe) |-> age_r inside {[4'h2:4'h6]})
    else $error("drive start off mdc");
  out_step_a: assert property (mdio_oe && $past(mdio_oe) && $changed(mdio_out) |-> age_r <= 4'h6)
    else $error("data step off mdc");
endmodule // hsc_regs_chk

bind hsc_regs hsc_regs_chk i_hsc_regs_chk (.clock(clock), .rst(rst), .mdc(mdc),
  .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .port_addr(port_addr),
  .channel_global_power_off_n(channel_global_power_off_n), .ana(ana));

//--- hsc_regs_tb.sv
`timescale 1ns/1ns
////////////////////////
// Self-checking bench for the serdes control registers.
module hsc_regs_tb;
  localparam logic [4:0] PA = 5'h03;
  localparam logic [4:0] DV = hsc_pkg::DEV_ADDR;
  localparam logic [1:0] WR = hsc_pkg::OP_WRITE;
  localparam logic [1:0] RD = hsc_pkg::OP_READ;
  localparam int         REF_MHZ = 156;
  localparam logic [6:0] X4 [16] = '{7'h00, 7'h00, 7'h10, 7'h14, 7'h18, 7'h20, 7'h21, 7'h28,
                                     7'h30, 7'h32, 7'h3C, 7'h40, 7'h42, 7'h50, 7'h64, 7'h00};
  logic              clock;
  logic              rst;
  logic              pd_n;
  logic              pin;
  logic              mdc;
  logic              mdio_out;
  logic              mdio_oe;
  logic              h_drv;
  logic              h_val;
  hsc_pkg::hsc_ana_s ana;
  int                err_count;
  int                checked;
  logic [15:0]       q;
  logic [15:0]       w;
  logic [15:0]       e;
  // An enabled driver wins the pin, otherwise the pull-up does.
  assign pin = mdio_oe ? mdio_out : (h_drv ? h_val : 1'b1);
  hsc_regs i_hsc_regs (.clock(clock), .rst(rst), .mdc(mdc), .mdio_in(pin),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .port_addr(PA), .channel_global_power_off_n(pd_n),
    .ana(ana));
  hsc_mdio_host i_hsc_mdio_host (.clock(clock), .pin(pin), .mdc(mdc), .drv(h_drv),
    .val(h_val));
  // Enables and power-off flag as one word.
  function automatic logic [15:0] pwr();
    return {13'h0000, ana.pll_enable, ana.tx_enable, ana.datapath_off};
  endfunction
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
    checked++;
    if (s !== x)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  // Address frame, then the operation itself.
  task automatic acc(input logic [1:0] op, input logic [15:0] a, input logic [15:0] d);
    i_hsc_mdio_host.frame(hsc_pkg::OP_ADDRESS, PA, DV, a, q);
    i_hsc_mdio_host.frame(op, PA, DV, d, q);
  endtask
  task automatic wrap_up();
    if (err_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_reset();
    acc(RD, hsc_pkg::REG_PLL, 16'h0000);
    chk("pll_rst", q, 16'h831D);
    acc(RD, hsc_pkg::REG_TXRX, 16'h0000);
    chk("txrx_rst", q, 16'hA848);
    chk("en_rst", pwr(), 16'h0006);
  endtask
  // Every multiplier code; low range chosen as managing software would.
  task automatic t_mult();
    logic [3:0] c;
    for (int i = 0; i < 16; i++)
    begin
      c = 4'(i);
      w = {6'h15, c[1:0], 1'b1, 1'(X4[c] * REF_MHZ < 10000), 2'h3, c};
      acc(WR, hsc_pkg::REG_PLL, w);
      acc(RD, hsc_pkg::REG_PLL, 16'h0000);
      chk("pll_reg", q, w);
      e = {1'b0, w[9:8], w[6], c, X4[c], (c < 4'h2 || c == 4'hF)};
      q = {1'b0, ana.pll_loop_bw_sel, ana.vco_low_range, ana.pll_multiplier_code,
           ana.pll_mult_x4, ana.pll_mult_reserved};
      chk("pll_ana", q, e);
    end
  endtask
  // Every code of rate, gain loop and auto-zero fields.
  task automatic t_txrx();
    logic [1:0] k;
    for (int i = 0; i < 4; i++)
    begin
      k = 2'(i);
      w = {4'(5 * i), k[1], k[0], k, k, k, 4'h8};
      acc(WR, hsc_pkg::REG_TXRX, w);
      acc(RD, hsc_pkg::REG_TXRX, 16'h0000);
      chk("txrx_reg", q, w);
      q = {4'h0, ana.tx_amplitude_code, ana.tx_enable, ana.equalizer_freeze,
           ana.tx_rate_code, ana.gain_loop_mode, ana.auto_zero_mode};
      chk("txrx_ana", q, {4'h0, w[15:4]});
    end
  endtask
  // Unmapped place, foreign port and foreign device must change nothing.
  task automatic t_refuse();
    acc(WR, 16'h0007, 16'hFFFF);
    acc(RD, 16'h0007, 16'h0000);
    chk("unmapped", q, 16'h0000);
    i_hsc_mdio_host.frame(hsc_pkg::OP_ADDRESS, PA, DV, hsc_pkg::REG_TXRX, q);
    i_hsc_mdio_host.frame(WR, PA ^ 5'h01, DV, 16'h0000, q);
    i_hsc_mdio_host.frame(WR, PA, 5'h1D, 16'h0000, q);
    acc(RD, hsc_pkg::REG_TXRX, 16'h0000);
    chk("foreign", q, 16'hFFF8);
  endtask
  // Read then advance: a plain read that follows lands on the next register.
  task automatic t_inc();
    acc(hsc_pkg::OP_READ_INC, hsc_pkg::REG_PLL, 16'h0000);
    chk("inc_first", q, 16'h57FF);
    i_hsc_mdio_host.frame(RD, PA, DV, 16'h0000, q);
    chk("inc_next", q, 16'hFFF8);
  endtask
  // Pin and global power-down both force the enables off.
  task automatic t_power();
    pd_n <= 1'b0;
    repeat (6) @(posedge clock);
    chk("pin_off", pwr(), 16'h0001);
    pd_n <= 1'b1;
    repeat (6) @(posedge clock);
    chk("pin_on", pwr(), 16'h0006);
    acc(WR, hsc_pkg::REG_POWER, 16'hFFFF);
    chk("glb_off", pwr(), 16'h0001);
    acc(RD, hsc_pkg::REG_POWER, 16'h0000);
    chk("pwr_reg", q, 16'h8000);
    acc(WR, hsc_pkg::REG_POWER, 16'h0000);
    chk("glb_on", pwr(), 16'h0006);
  endtask
  // Clock of 20 ns.
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // About a hundred frames of 650 cycles fit well inside this span.
  initial
  begin
    repeat (90000) @(posedge clock);
    err_count++;
    wrap_up();
  end
  // Reset for four cycles, then the scenarios.
  initial
  begin
    rst = 1'b1;
    pd_n = 1'b1;
    err_count = 0;
    checked = 0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    t_reset();
    t_mult();
    t_txrx();
    t_refuse();
    t_inc();
    t_power();
    wrap_up();
  end
endmodule // hsc_regs_tb
